// file: rtl/prescaler_interval_timer.sv
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
//Contract
// - The system clock is the oscillator clock divided by two.
// - The prescaler is a 12-bit up-counter on the oscillator clock.
// - Every prescaler bit is offered as a divided clock tap.
// - The interval counter is 8 bits, free running, never halted by software.
// - The counter steps once per pulse of a tap from divide-8 to divide-1024.
// - Wrapping from the maximum to zero sets the interval interrupt flag.
// - Writing one to the clear bit zeroes the counter, which then counts on.
// - The clear bit returns to zero by itself one machine cycle later.
// - Stop with the wake bit set keeps only the divide-2048 tap running.
// - Stop with the RC watchdog bit set keeps the interval timer running.
// - The guard timer on bit picks watchdog or plain 7-bit timer use.
// - One address reads the counter and writes the control word.
module prescaler_interval_timer (
  // Clock and reset.
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  // AXI4-Lite write address.
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  // AXI4-Lite write data.
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // AXI4-Lite read address.
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // Clock outputs to peripherals.
  output logic                          sys_clk_en,
  output logic [11:0]                   prescaler_taps,
  // Power control.
  input  wire logic                     stop_cmd,
  input  wire logic                     wake_evt,
  output clock_gen_pkg::power_mode_e    power_mode,
  output logic                          guard_timer_on_bit,
  output logic                          interval_tick,
  // Interrupt.
  output logic                          irq
);
  import clock_gen_pkg::*;

  tap_bus_if tb ();

  logic [7:0]  clock_control_word_r;
  logic [7:0]  interval_count_value_r;
  logic        counter_clear_bit_r;
  logic [7:0]  irq_status_r;
  logic [7:0]  irq_mask_r;
  power_mode_e mode_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        aw_have_r;
  logic        w_have_r;
  logic        wr_go;
  logic        count_step;
  logic        ovf_evt;
  logic        div_toggle;
  logic [7:0]  irq_status_nxt;
  logic        sel_tap_is_ten;
  logic [31:0] rdata_nxt;
  logic        rd_hit;

  // One decode for every register write; byte lane 0 carries each register.
  function automatic logic write_hits(input logic       go,
                                      input logic [7:0] addr,
                                      input logic [3:0] strb,
                                      input logic [7:0] target);
    return go && (addr == target) && strb[0];
  endfunction

  // Registers that take a write; the mode word is read-only.
  function automatic logic write_mapped(input logic [7:0] addr);
    return (addr == ADDR_SHARED) || (addr == ADDR_IRQ_STATUS) ||
           (addr == ADDR_IRQ_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  sysclk_div2 u_div (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .sys_clk_en (div_toggle)
  );

  prescaler12 u_pre (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tb      (tb)
  );

  // The divided clock is held low in every standby mode, where the CPU
  // side must halt; the toggle flop keeps its phase meanwhile.
  assign sys_clk_en = div_toggle && (mode_r == MODE_RUN);

  // Plain stop halts the prescaler; wake-up and RC modes keep it counting.
  always_comb begin
    tb.sel = clock_control_word_r[CTL_SEL_LSB +: CTL_SEL_W];
    tb.run = (mode_r != MODE_STOP);
  end

  // In wake-up mode only the divide-2048 tap is passed on.
  always_comb begin
    if (mode_r == MODE_WAKE_TIMER) begin
      prescaler_taps = 12'h000;
      prescaler_taps[WAKE_TAP] = tb.taps[WAKE_TAP];
    end else begin
      prescaler_taps = tb.taps;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The counter runs except in plain stop and wake-up timer modes; no software bit halts it.
  assign count_step = tb.count_pulse && (mode_r != MODE_WAKE_TIMER);
  // A clear in the same cycle wins, so the counter never wraps then.
  assign ovf_evt = count_step && !counter_clear_bit_r &&
                   (interval_count_value_r == COUNT_MAX);
  assign interval_tick = ovf_evt;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      interval_count_value_r <= COUNT_RESET;
    end else if (counter_clear_bit_r) begin
      interval_count_value_r <= COUNT_RESET;
    end else if (count_step) begin
      interval_count_value_r <= interval_count_value_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The clear bit is a one-cycle strobe, so it never stores into the word.
  // The word cannot be read back, so software must keep its own copy and
  // always write the whole byte.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clock_control_word_r <= CTL_RESET;
      counter_clear_bit_r  <= 1'b0;
    end else begin
      counter_clear_bit_r <= 1'b0;
      if (write_hits(wr_go, awaddr_r, wstrb_r, ADDR_SHARED)) begin
        clock_control_word_r <= wdata_r[7:0] &
                                ~(8'h01 << CTL_CLEAR_BIT);
        counter_clear_bit_r  <= wdata_r[CTL_CLEAR_BIT];
      end
    end
  end

  assign guard_timer_on_bit = clock_control_word_r[CTL_WDT_ON_BIT];
  assign sel_tap_is_ten = (tb.sel == 3'(WAKE_TAP - SEL_TAP_BASE - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Stop picks its mode from the control bits at the moment it executes.
  // Select code 7 (tap nine) keeps the counter alive through stop, so it can time
  // the oscillator settling after wake-up.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_r <= MODE_RUN;
    end else begin
      case (mode_r)
        MODE_RUN: begin
          if (stop_cmd) begin
            if (clock_control_word_r[CTL_WAKE_BIT]) begin
              mode_r <= MODE_WAKE_TIMER;
            end else if (clock_control_word_r[CTL_RC_GUARD_MODE_BIT_BIT]) begin
              mode_r <= MODE_RC_WATCHDOG;
            end else if (sel_tap_is_ten) begin
              mode_r <= MODE_RC_WATCHDOG;
            end else begin
              mode_r <= MODE_STOP;
            end
          end
        end
        MODE_WAKE_TIMER, MODE_RC_WATCHDOG, MODE_STOP: begin
          if (wake_evt || (ovf_evt && irq_mask_r[IRQ_OVF_BIT])) begin
            mode_r <= MODE_RUN;
          end
        end
        default: mode_r <= MODE_RUN;
      endcase
    end
  end

  assign power_mode = mode_r;

  ////////////////////////////////////////////////////////////////////////////
  // Set wins over a write-one clear in the same cycle.
  always_comb begin
    irq_status_nxt = irq_status_r;
    if (write_hits(wr_go, awaddr_r, wstrb_r, ADDR_IRQ_STATUS)) begin
      irq_status_nxt = irq_status_r & ~wdata_r[7:0];
    end
    if (ovf_evt) begin
      irq_status_nxt[IRQ_OVF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_status_r <= IRQ_RESET;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_mask_r <= IRQ_RESET;
    end else if (write_hits(wr_go, awaddr_r, wstrb_r, ADDR_IRQ_MASK)) begin
      irq_mask_r <= wdata_r[7:0];
    end
  end

  assign irq = |(irq_status_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Write path: address and data are latched separately, in either order.
  // Each ready drops while its own half is held or the answer waits, so wr_go is
  // a one-cycle pulse and only one write is ever in flight.
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
  assign wr_go         = aw_have_r && w_have_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else if (wr_go) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= write_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: the shared address returns the live counter, not the control.
  // The counter is sampled when the address is taken, not when the data is
  // accepted.
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_hit    = 1'b1;
    rdata_nxt = 32'h0000_0000;
    case ({s_axi_araddr[7:2], 2'b00})
      ADDR_SHARED:     rdata_nxt[7:0] = interval_count_value_r;
      ADDR_IRQ_STATUS: rdata_nxt[7:0] = irq_status_r;
      ADDR_IRQ_MASK:   rdata_nxt[7:0] = irq_mask_r;
      ADDR_STANDBY:    rdata_nxt[1:0] = mode_r;
      default:         rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata_nxt;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // prescaler_interval_timer

// file: rtl/clock_gen_pkg.sv
package clock_gen_pkg;

  // Shared register address; reads return the counter, writes the control.
  localparam logic [7:0] ADDR_SHARED     = 8'hec;
  // Interrupt status and mask words.
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hf0;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'hf4;
  // Standby mode status word; read-only.
  localparam logic [7:0] ADDR_STANDBY    = 8'hf8;

  // Control word field positions.
  localparam int CTL_SEL_LSB    = 0;
  localparam int CTL_SEL_W      = 3;
  localparam int CTL_CLEAR_BIT  = 3;
  localparam int CTL_WDT_ON_BIT = 4;
  localparam int CTL_RC_GUARD_MODE_BIT_BIT  = 5;
  localparam int CTL_WAKE_BIT   = 6;

  // Reset values.
  localparam logic [7:0]  CTL_RESET      = 8'h00;
  localparam logic [11:0] PRESCALE_RESET = 12'h000;
  localparam logic [7:0]  COUNT_RESET    = 8'h00;
  localparam logic [7:0]  COUNT_MAX      = 8'hff;
  localparam logic [7:0]  IRQ_RESET      = 8'h00;

  // Select code n picks tap n+2, so codes 0..7 give divide-by-8..1024.
  localparam int SEL_TAP_BASE  = 2;
  // Tap that gives divide-by-2048 in wake-up timer mode.
  localparam int WAKE_TAP      = 10;
  localparam int PRESCALE_W    = 12;

  // Interrupt status bit positions.
  localparam int IRQ_OVF_BIT   = 0;

  // AXI4-Lite responses.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_WAKE_TIMER,
    MODE_RC_WATCHDOG,
    MODE_STOP
  } power_mode_e;

endpackage

// file: rtl/tap_bus_if.sv
`timescale 1ns/1ps
interface tap_bus_if;
  logic [11:0] taps;
  logic [2:0]  sel;
  logic        count_pulse;
  logic        run;
  modport src (output taps, output count_pulse, input sel, input run);
  modport dst (input taps, input count_pulse, output sel, output run);
endinterface // tap_bus_if

// file: rtl/prescaler12.sv
`timescale 1ns/1ps
module prescaler12 (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst,
  // Divider bus.
  tap_bus_if.src    tb
);
  import clock_gen_pkg::*;

  logic [11:0] prescale_r;
  logic [11:0] prescale_nxt;
  logic [11:0] taps_prev_r;

  assign prescale_nxt = prescale_r + 12'h001;

  // Counts every oscillator edge unless the block is halted.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prescale_r <= PRESCALE_RESET;
    end else if (tb.run) begin
      prescale_r <= prescale_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      taps_prev_r <= PRESCALE_RESET;
    end else begin
      taps_prev_r <= prescale_r;
    end
  end

  assign tb.taps = prescale_r;

  // A falling edge of the chosen tap is one count pulse; this keeps the
  // count rate exact at one per full tap period.
  always_comb begin
    tb.count_pulse = taps_prev_r[int'(tb.sel) + SEL_TAP_BASE] &
                     ~prescale_r[int'(tb.sel) + SEL_TAP_BASE];
  end
endmodule // prescaler12

// file: rtl/sysclk_div2.sv
`timescale 1ns/1ps
module sysclk_div2 (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst,
  // Divided clock.
  output logic      sys_clk_en
);
  // Toggle flop; the system clock is a one-in-two enable, not a new clock.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sys_clk_en <= 1'b0;
    end else begin
      sys_clk_en <= ~sys_clk_en;
    end
  end
endmodule // sysclk_div2

// file: testbench/prescaler_interval_timer_asserts.sv
`timescale 1ns/1ps
module prescaler_interval_timer_asserts (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Bus answers.
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Timer outputs.
  input wire logic        sys_clk_en,
  input wire logic [11:0] prescaler_taps,
  input clock_gen_pkg::power_mode_e power_mode,
  input wire logic        guard_timer_on_bit,
  input wire logic        interval_tick,
  input wire logic        irq
);
  import clock_gen_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_sysclk_half: assert property (
    !$past(rst) && power_mode == MODE_RUN && $past(power_mode) == MODE_RUN
    |-> sys_clk_en != $past(sys_clk_en)) else $error("no toggle");
  a_sysclk_idle: assert property (
    power_mode != MODE_RUN |-> !sys_clk_en) else $error("clock not idle");
  // Only checked in run mode; of the standby modes only plain stop freezes the divider.
  a_prescale_step: assert property (
    !$past(rst) && power_mode == MODE_RUN && $past(power_mode) == MODE_RUN
    |-> prescaler_taps == $past(prescaler_taps) + 12'h001)
    else $error("prescaler step");
  a_wake_taps: assert property (
    power_mode == MODE_WAKE_TIMER |-> (prescaler_taps & 12'hbff) == 12'h000)
    else $error("wake taps");
  a_tick_spacing: assert property (
    interval_tick |=> !interval_tick [*7]) else $error("tick spacing");
  a_irq_cause: assert property (
    $rose(irq) |-> $past(interval_tick) || s_axi_bvalid)
    else $error("irq cause");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read");
  a_read_done: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read held");
  a_write_done: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("resp held");
  a_guard_write: assert property (
    guard_timer_on_bit != $past(guard_timer_on_bit) |-> s_axi_bvalid)
    else $error("guard moved");
endmodule // prescaler_interval_timer_asserts
////////////////////////////////////////
bind prescaler_interval_timer prescaler_interval_timer_asserts chk_inst (
  .clk_sys(clk_sys), .rst(rst), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .sys_clk_en(sys_clk_en),
  .prescaler_taps(prescaler_taps), .power_mode(power_mode),
  .guard_timer_on_bit(guard_timer_on_bit), .interval_tick(interval_tick),
  .irq(irq));

// file: testbench/prescaler_interval_timer_tb_top.sv
`timescale 1ns/1ps
module prescaler_interval_timer_tb_top;
  import clock_gen_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic stop_cmd = 1'b0, wake_evt = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, lfsr = 32'h0000_f69d;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, guard_on, tick, irq, sck;
  logic [1:0] bresp, rresp;
  logic [11:0] taps;
  power_mode_e mode;
  int bad_count = 0, samples_checked = 0;
  always #25 clk_sys = ~clk_sys;
  prescaler_interval_timer prescaler_interval_timer_inst (
    .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sys_clk_en(sck), .prescaler_taps(taps),
    .stop_cmd(stop_cmd), .wake_evt(wake_evt), .power_mode(mode),
    .guard_timer_on_bit(guard_on), .interval_tick(tick), .irq(irq));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Select code c counts one pulse per 8 << c oscillator cycles.
  function automatic logic [31:0] tap_period(input int c);
    return 32'h0000_0008 << c;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Readys are sampled before the edge's updates land, as the slave sees them.
  task automatic wchk(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(d, e);
    check({30'h0, r}, {30'h0, er});
  endtask
  task automatic go(input logic st, input power_mode_e m);
    @(posedge clk_sys);
    stop_cmd <= st;
    wake_evt <= !st;
    @(posedge clk_sys);
    stop_cmd <= 1'b0;
    wake_evt <= 1'b0;
    @(posedge clk_sys);
    check({30'h0, mode}, {30'h0, m});
  endtask
  ////////////////////////////////////////
  initial begin
    logic [31:0] d, k, t;
    logic [1:0] r;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rchk(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
    k = {31'h0, sck};
    @(posedge clk_sys);
    check({31'h0, sck}, {31'h0, ~k[0]});
    rchk(ADDR_STANDBY, 32'h0, RESP_OKAY);
    rchk(8'h00, 32'h0, RESP_SLVERR);
    wchk(8'h00, 32'h1, 4'hf, RESP_SLVERR);
    wchk(ADDR_SHARED, 32'h10, 4'h1, RESP_OKAY);
    check({31'h0, guard_on}, 32'h1);
    wchk(ADDR_SHARED, 32'h0, 4'h0, RESP_OKAY);
    check({31'h0, guard_on}, 32'h1);
    for (int c = 0; c < 8; c++) begin
      lfsr = lfsr_next(lfsr);
      k = {30'h0, lfsr[1:0]} + 32'h1;
      wchk(ADDR_SHARED, {lfsr[31:8], 5'h01, 3'(c)}, 4'h1, RESP_OKAY);
      repeat (k * tap_period(c)) @(posedge clk_sys);
      rd(ADDR_SHARED, d, r);
      check({31'h0, d == k || d == k + 1}, 32'h1);
    end
    wchk(ADDR_SHARED, 32'h8, 4'h1, RESP_OKAY);
    repeat (2200) @(posedge clk_sys);
    check({31'h0, irq}, 32'h0);
    rchk(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
    wchk(ADDR_IRQ_MASK, 32'h1, 4'h1, RESP_OKAY);
    check({31'h0, irq}, 32'h1);
    wchk(ADDR_IRQ_STATUS, 32'h1, 4'h1, RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    t = 0;
    k = 0;
    while (irq !== 1'b1 && t < 3000) begin
      @(posedge clk_sys);
      if (tick === 1'b1) k = 1;
      t++;
    end
    check({31'h0, irq}, 32'h1);
    check(k, 32'h1);
    wchk(ADDR_IRQ_MASK, 32'h0, 4'h1, RESP_OKAY);
    wchk(ADDR_SHARED, 32'h40, 4'h1, RESP_OKAY);
    go(1'b1, MODE_WAKE_TIMER);
    check({20'h0, taps & 12'hbff}, 32'h0);
    check({31'h0, sck}, 32'h0);
    go(1'b0, MODE_RUN);
    wchk(ADDR_SHARED, 32'h20, 4'h1, RESP_OKAY);
    go(1'b1, MODE_RC_WATCHDOG);
    rd(ADDR_SHARED, d, r);
    repeat (64) @(posedge clk_sys);
    rd(ADDR_SHARED, t, r);
    check({31'h0, t != d}, 32'h1);
    go(1'b0, MODE_RUN);
    wchk(ADDR_SHARED, 32'h07, 4'h1, RESP_OKAY);
    go(1'b1, MODE_RC_WATCHDOG);
    go(1'b0, MODE_RUN);
    wchk(ADDR_SHARED, 32'h00, 4'h1, RESP_OKAY);
    go(1'b1, MODE_STOP);
    go(1'b0, MODE_RUN);
    give_verdict();
  end
  // Longest path is the rate sweep plus two overflow periods.
  initial begin
    repeat (40000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end
endmodule // prescaler_interval_timer_tb_top
